// file: include/mbs_pkg.sv
// Functional notes
// - automatic mode releases the brake only in operation enabled; otherwise closed. The code also keeps it released in ST_STOP and ST_WAIT_ENG.
// - submode bit 2 high selects automatic brake control, low selects manual.
// - manual mode drives the brake straight from digital output bit 0.
// - on enable: current on, wait delay 3, release, wait delay 4, allow travel.
// - on leaving: stop motor, wait delay 1, engage, wait delay 2, current off.
// - an energised brake is driven as PWM unless full duty is selected.
// - PWM frequency is in hertz, limited to 50 through 20000.
// - PWM duty is a percentage of the period, from 2 to 100.
// - duty of 100 holds the brake output steadily on.
// - brake PWM is a routable output source, true and inverted.
package mbs_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 250_000_000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int MS_TIME_NS = 1_000_000;
    localparam int MS_CYCLES = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ---------------------------------------------------------------
    // field widths and positions
    // ---------------------------------------------------------------
    localparam int DELAY_W = 16;
    localparam int FREQ_W = 16;
    localparam int DUTY_W = 7;
    localparam int PER_W = 23;
    localparam int DOUT_W = 32;
    localparam int SUBMODE_W = 16;
    localparam int SUBMODE_AUTO_BIT = 2;
    localparam int DOUT_BRAKE_BIT = 0;
    localparam int ROUTE_INV_BIT = 7;
    localparam int ROUTE_IDX_W = 5;
    // ---------------------------------------------------------------
    // pwm limits
    // ---------------------------------------------------------------
    localparam logic [FREQ_W-1:0] PWM_FREQ_MIN_HZ = 16'h0032;
    localparam logic [FREQ_W-1:0] PWM_FREQ_MAX_HZ = 16'h4E20;
    localparam logic [DUTY_W-1:0] PWM_DUTY_MIN = 7'h02;
    localparam logic [DUTY_W-1:0] PWM_DUTY_FULL = 7'h64;
    localparam int PCT_SCALE = 100;
    // ---------------------------------------------------------------
    // routing source codes (high byte)
    // ---------------------------------------------------------------
    localparam logic [7:0] ROUTE_SRC_ONE = 8'h00;
    localparam logic [7:0] ROUTE_SRC_ZERO = 8'h01;
    localparam logic [7:0] ROUTE_SRC_PWM = 8'h10;
    localparam logic [7:0] ROUTE_SRC_PWM_INV = 8'h11;
    // ---------------------------------------------------------------
    // brake sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_WAIT_ON = 7'h02,
        ST_WAIT_REL = 7'h04,
        ST_ENABLED = 7'h08,
        ST_STOP = 7'h10,
        ST_WAIT_ENG = 7'h20,
        ST_WAIT_OFF = 7'h40
    } mbs_state_t;
endpackage

// file: include/mbs_pwm_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mbs_pwm_if;
    logic enable;
    logic [15:0] freq_hz;
    logic [6:0] duty_pct;
    logic wave;
    logic full_on;
    modport gen (input enable, input freq_hz, input duty_pct, output wave, output full_on);
    modport ctl (output enable, output freq_hz, output duty_pct, input wave, input full_on);
endinterface
`default_nettype wire

// file: rtl/mbs_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_pwm (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // settings and waveform
    mbs_pwm_if.gen pif
);
    logic [mbs_pkg::FREQ_W-1:0] freq_c;
    logic [mbs_pkg::DUTY_W-1:0] duty_c;
    logic [mbs_pkg::PER_W-1:0] period_w;
    logic [mbs_pkg::PER_W-1:0] high_w;
    logic [31:0] prod_w;
    logic [mbs_pkg::PER_W-1:0] cnt_reg;
    logic [mbs_pkg::PER_W-1:0] period_reg;
    logic [mbs_pkg::PER_W-1:0] high_reg;
    logic wave_reg;
    logic full_reg;
    logic wrap_w;

    // clamp settings into their legal ranges
    assign freq_c = (pif.freq_hz < mbs_pkg::PWM_FREQ_MIN_HZ) ? mbs_pkg::PWM_FREQ_MIN_HZ :
                    (pif.freq_hz > mbs_pkg::PWM_FREQ_MAX_HZ) ? mbs_pkg::PWM_FREQ_MAX_HZ :
                    pif.freq_hz;
    assign duty_c = (pif.duty_pct < mbs_pkg::PWM_DUTY_MIN) ? mbs_pkg::PWM_DUTY_MIN :
                    (pif.duty_pct > mbs_pkg::PWM_DUTY_FULL) ? mbs_pkg::PWM_DUTY_FULL :
                    pif.duty_pct;
    assign period_w = mbs_pkg::PER_W'(mbs_pkg::CLK_FREQ_HZ / int'(freq_c));
    assign prod_w = 32'(period_w) * 32'(duty_c);
    assign high_w = mbs_pkg::PER_W'(prod_w / 32'(mbs_pkg::PCT_SCALE));
    assign wrap_w = (cnt_reg >= period_reg - mbs_pkg::PER_W'(1));

    // new settings other than full duty take effect at a period boundary to avoid runt pulses
    always_ff @(posedge clk_sys) begin
        if (rst || !pif.enable) begin
            cnt_reg <= '0;
            period_reg <= period_w;
            high_reg <= high_w;
            wave_reg <= 1'b0;
            full_reg <= 1'b0;
        end else begin
            cnt_reg <= wrap_w ? '0 : cnt_reg + mbs_pkg::PER_W'(1);
            if (wrap_w) begin
                period_reg <= period_w;
                high_reg <= high_w;
            end
            wave_reg <= (cnt_reg < high_reg);
            full_reg <= (duty_c == mbs_pkg::PWM_DUTY_FULL);
        end
    end

    assign pif.wave = wave_reg;
    assign pif.full_on = full_reg;

    property p_period_range;
        @(posedge clk_sys) disable iff (rst)
        pif.enable
            |-> (period_reg >= mbs_pkg::PER_W'(mbs_pkg::CLK_FREQ_HZ / int'(mbs_pkg::PWM_FREQ_MAX_HZ)))
            && (period_reg <= mbs_pkg::PER_W'(mbs_pkg::CLK_FREQ_HZ / int'(mbs_pkg::PWM_FREQ_MIN_HZ)));
    endproperty
    a_period_range: assert property (p_period_range) else $error("pwm period out of range");

    property p_high_le_period;
        @(posedge clk_sys) disable iff (rst)
        pif.enable |-> high_reg <= period_reg
            && high_reg >= period_reg / mbs_pkg::PER_W'(mbs_pkg::PCT_SCALE / int'(mbs_pkg::PWM_DUTY_MIN));
    endproperty
    a_high_le_period: assert property (p_high_le_period) else $error("pwm high time wrong");
endmodule
`default_nettype wire

// file: rtl/mbs_top.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_top #(
    parameter int MS_CYCLES = mbs_pkg::MS_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // configuration
    input wire logic [mbs_pkg::SUBMODE_W-1:0] drive_submode_select,
    input wire logic [mbs_pkg::DOUT_W-1:0] digital_output_control_word,
    input wire logic [15:0] output_routing_select,
    // brake timing settings, delays in ms
    input wire logic [mbs_pkg::DELAY_W-1:0] brake_delay_stop_ms,
    input wire logic [mbs_pkg::DELAY_W-1:0] brake_delay_engage_ms,
    input wire logic [mbs_pkg::DELAY_W-1:0] brake_delay_on_ms,
    input wire logic [mbs_pkg::DELAY_W-1:0] brake_delay_release_ms,
    input wire logic [mbs_pkg::FREQ_W-1:0] brake_pwm_freq_hz,
    input wire logic [mbs_pkg::DUTY_W-1:0] brake_pwm_duty_pct,
    // power state machine
    input wire logic op_enabled,
    input wire logic motor_standstill,
    // drive control
    output logic motor_current_on,
    output logic halt_motion,
    output logic travel_enable,
    // brake and routed output
    output logic brake_energised,
    output logic brake_out,
    output logic routed_out
);
    mbs_pkg::mbs_state_t state_reg, state_next;
    logic [31:0] tick_cnt_reg;
    logic tick_w;
    logic [mbs_pkg::DELAY_W-1:0] ms_cnt_reg;
    logic [mbs_pkg::DELAY_W-1:0] delay_sel_w;
    logic delay_done_w;
    logic auto_w;
    logic auto_rel_w;
    logic energise_w;
    logic pwm_level_w;
    logic route_ctrl_w;
    logic route_src_w;
    logic [7:0] route_code_w;
    logic current_reg, halt_reg, travel_reg, energ_reg, brake_reg, route_reg;

    mbs_pwm_if pwm_if ();

    // ---------------------------------------------------------------
    // millisecond tick
    // ---------------------------------------------------------------
    assign tick_w = (tick_cnt_reg == 32'(MS_CYCLES - 1));

    always_ff @(posedge clk_sys) begin
        if (rst || tick_w) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
        end
    end

    // ---------------------------------------------------------------
    // delay of the current step
    // ---------------------------------------------------------------
    assign delay_sel_w = (state_reg == mbs_pkg::ST_WAIT_ON) ? brake_delay_on_ms :
                         (state_reg == mbs_pkg::ST_WAIT_REL) ? brake_delay_release_ms :
                         (state_reg == mbs_pkg::ST_WAIT_ENG) ? brake_delay_stop_ms :
                         (state_reg == mbs_pkg::ST_WAIT_OFF) ? brake_delay_engage_ms :
                         '0;
    assign delay_done_w = (ms_cnt_reg >= delay_sel_w);

    always_ff @(posedge clk_sys) begin
        if (rst || state_next != state_reg) begin
            ms_cnt_reg <= '0;
        end else if (tick_w && !delay_done_w) begin
            ms_cnt_reg <= ms_cnt_reg + mbs_pkg::DELAY_W'(1);
        end
    end

    // ---------------------------------------------------------------
    // brake sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mbs_pkg::ST_IDLE: begin
                if (op_enabled) begin
                    state_next = mbs_pkg::ST_WAIT_ON;
                end
            end
            mbs_pkg::ST_WAIT_ON: begin
                if (!op_enabled) begin
                    // brake never opened: skip the stop steps, keep current for the last delay
                    state_next = mbs_pkg::ST_WAIT_OFF;
                end else if (delay_done_w) begin
                    state_next = mbs_pkg::ST_WAIT_REL;
                end
            end
            mbs_pkg::ST_WAIT_REL: begin
                if (!op_enabled) begin
                    state_next = mbs_pkg::ST_STOP;
                end else if (delay_done_w) begin
                    state_next = mbs_pkg::ST_ENABLED;
                end
            end
            mbs_pkg::ST_ENABLED: begin
                if (!op_enabled) begin
                    state_next = mbs_pkg::ST_STOP;
                end
            end
            mbs_pkg::ST_STOP: begin
                if (motor_standstill) begin
                    state_next = mbs_pkg::ST_WAIT_ENG;
                end
            end
            mbs_pkg::ST_WAIT_ENG: begin
                if (delay_done_w) begin
                    state_next = mbs_pkg::ST_WAIT_OFF;
                end
            end
            mbs_pkg::ST_WAIT_OFF: begin
                if (delay_done_w) begin
                    state_next = mbs_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = mbs_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= mbs_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ---------------------------------------------------------------
    // brake drive
    // ---------------------------------------------------------------
    assign auto_w = drive_submode_select[mbs_pkg::SUBMODE_AUTO_BIT];
    assign auto_rel_w = (state_next == mbs_pkg::ST_WAIT_REL)
                     || (state_next == mbs_pkg::ST_ENABLED)
                     || (state_next == mbs_pkg::ST_STOP)
                     || (state_next == mbs_pkg::ST_WAIT_ENG);
    assign energise_w = auto_w ? auto_rel_w
                      : digital_output_control_word[mbs_pkg::DOUT_BRAKE_BIT];
    assign pwm_level_w = energ_reg && (pwm_if.full_on || pwm_if.wave);

    assign pwm_if.enable = energ_reg;
    assign pwm_if.freq_hz = brake_pwm_freq_hz;
    assign pwm_if.duty_pct = brake_pwm_duty_pct;

    mbs_pwm u_pwm (
        .clk_sys(clk_sys),
        .rst(rst),
        .pif(pwm_if.gen)
    );

    // ---------------------------------------------------------------
    // output routing
    // ---------------------------------------------------------------
    assign route_code_w = output_routing_select[15:8];
    assign route_ctrl_w = digital_output_control_word[output_routing_select[mbs_pkg::ROUTE_IDX_W-1:0]]
                        ^ output_routing_select[mbs_pkg::ROUTE_INV_BIT];
    assign route_src_w = (route_code_w == mbs_pkg::ROUTE_SRC_ONE) ? 1'b1 :
                         (route_code_w == mbs_pkg::ROUTE_SRC_PWM) ? pwm_level_w :
                         (route_code_w == mbs_pkg::ROUTE_SRC_PWM_INV) ? !pwm_level_w :
                         1'b0;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            current_reg <= 1'b0;
            halt_reg <= 1'b0;
            travel_reg <= 1'b0;
            energ_reg <= 1'b0;
            brake_reg <= 1'b0;
            route_reg <= 1'b0;
        end else begin
            current_reg <= (state_next != mbs_pkg::ST_IDLE);
            halt_reg <= (state_next == mbs_pkg::ST_STOP) || (state_next == mbs_pkg::ST_WAIT_ENG);
            travel_reg <= (state_next == mbs_pkg::ST_ENABLED);
            energ_reg <= energise_w;
            brake_reg <= pwm_level_w;
            route_reg <= route_src_w && route_ctrl_w;
        end
    end

    assign motor_current_on = current_reg;
    assign halt_motion = halt_reg;
    assign travel_enable = travel_reg;
    assign brake_energised = energ_reg;
    assign brake_out = brake_reg;
    assign routed_out = route_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_auto_closed;
        auto_w && $past(auto_w) && !op_enabled && !$past(op_enabled)
            && state_reg == mbs_pkg::ST_IDLE |-> !brake_energised;
    endproperty
    a_auto_closed: assert property (p_auto_closed) else $error("brake open outside enable");

    property p_mode_select;
        auto_w && state_next == mbs_pkg::ST_ENABLED |=> brake_energised;
    endproperty
    a_mode_select: assert property (p_mode_select) else $error("auto mode not released");

    property p_manual;
        !auto_w |=> brake_energised
            == $past(digital_output_control_word[mbs_pkg::DOUT_BRAKE_BIT]);
    endproperty
    a_manual: assert property (p_manual) else $error("manual brake not followed");

    property p_enable_order;
        $rose(travel_enable) |-> motor_current_on
            && $past(state_reg) == mbs_pkg::ST_WAIT_REL && $past(delay_done_w);
    endproperty
    a_enable_order: assert property (p_enable_order) else $error("travel before delay");

    property p_release_order;
        state_reg == mbs_pkg::ST_WAIT_ON && state_next == mbs_pkg::ST_WAIT_REL
            |-> delay_done_w && motor_current_on;
    endproperty
    a_release_order: assert property (p_release_order) else $error("release before delay");

    property p_off_order;
        $fell(motor_current_on) |-> $past(state_reg) == mbs_pkg::ST_WAIT_OFF && $past(delay_done_w);
    endproperty
    a_off_order: assert property (p_off_order) else $error("current off too early");

    property p_no_pwm_off;
        !brake_energised |=> !brake_out;
    endproperty
    a_no_pwm_off: assert property (p_no_pwm_off) else $error("brake driven while off");

    property p_full_duty;
        brake_energised && pwm_if.full_on |=> brake_out;
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty not steady");

    property p_route_pwm;
        route_code_w == mbs_pkg::ROUTE_SRC_PWM && route_ctrl_w |=> routed_out == $past(pwm_level_w);
    endproperty
    a_route_pwm: assert property (p_route_pwm) else $error("pwm routing wrong");

    property p_step_wait;
        state_reg == mbs_pkg::ST_WAIT_ENG && state_next != state_reg |-> ms_cnt_reg >= brake_delay_stop_ms;
    endproperty
    a_step_wait: assert property (p_step_wait) else $error("step advanced early");
endmodule
`default_nettype wire

// file: verif/mbs_coil_model.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_coil_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // coil drive
    input wire logic brake_out,
    // measurements
    output var int rises,
    output var int period_cycles,
    output var int high_cycles
);
    logic prev_reg;
    int cnt_reg;
    int hcnt_reg;

    // -----------------------------------------------------------
    // coil load: measures each period from rising edge to rising edge
    // -----------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        prev_reg <= brake_out;
        if (rst) begin
            rises <= 0;
            period_cycles <= 0;
            high_cycles <= 0;
            cnt_reg <= 0;
            hcnt_reg <= 0;
        end else if (brake_out && !prev_reg) begin
            rises <= rises + 1;
            period_cycles <= cnt_reg;
            high_cycles <= hcnt_reg;
            cnt_reg <= 1;
            hcnt_reg <= 1;
        end else begin
            cnt_reg <= cnt_reg + 1;
            hcnt_reg <= hcnt_reg + (brake_out ? 1 : 0);
        end
    end
endmodule
`default_nettype wire

// file: verif/tb_motor_brake_sequencer_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module tb_motor_brake_sequencer_pwm;
    localparam int MSC = 10;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [15:0] submode = 16'h0004;
    logic [31:0] dout_word = 32'h00000000;
    logic [15:0] route_sel = 16'h0000;
    logic [15:0] d_stop = 16'h0002;
    logic [15:0] d_eng = 16'h0002;
    logic [15:0] d_on = 16'h0003;
    logic [15:0] d_rel = 16'h0002;
    logic [15:0] freq = 16'h4E20;
    logic [6:0] duty = 7'h19;
    logic op_en = 1'b0;
    logic standstill = 1'b0;
    wire logic cur_on;
    wire logic halt;
    wire logic travel;
    wire logic energised;
    wire logic brake_out;
    wire logic routed_out;
    wire logic [3:0] outs;
    int rises;
    int per;
    int hi;
    int bad_count = 0;
    int check_count = 0;
    integer seed = 32'h5993;
    int lowc;

    assign outs = {travel, energised, halt, cur_on};
    always #2 clk_sys = ~clk_sys;

    mbs_top #(.MS_CYCLES(MSC)) mbs_top_inst (
        .clk_sys(clk_sys), .rst(rst), .drive_submode_select(submode),
        .digital_output_control_word(dout_word), .output_routing_select(route_sel),
        .brake_delay_stop_ms(d_stop), .brake_delay_engage_ms(d_eng),
        .brake_delay_on_ms(d_on), .brake_delay_release_ms(d_rel),
        .brake_pwm_freq_hz(freq), .brake_pwm_duty_pct(duty),
        .op_enabled(op_en), .motor_standstill(standstill),
        .motor_current_on(cur_on), .halt_motion(halt), .travel_enable(travel),
        .brake_energised(energised), .brake_out(brake_out), .routed_out(routed_out)
    );

    mbs_coil_model mbs_coil_model_inst (
        .clk_sys(clk_sys), .rst(rst), .brake_out(brake_out),
        .rises(rises), .period_cycles(per), .high_cycles(hi)
    );

    // -----------------------------------------------------------
    // reference model and helpers
    // -----------------------------------------------------------
    function automatic int exp_period(input int f);
        int fc;
        fc = (f < 50) ? 50 : ((f > 20000) ? 20000 : f);
        return 250_000_000 / fc;
    endfunction

    function automatic int exp_high(input int f, input int d);
        int dc;
        dc = (d < 2) ? 2 : ((d > 100) ? 100 : d);
        return exp_period(f) * dc / 100;
    endfunction

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic timeout;
        bad_count++;
        $display("Error at %0t: wait limit reached", $time);
        print_verdict();
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // waits for an output to reach a level within the delay bound
    task automatic timed_wait(input int idx, input logic val, input int ms);
        int cyc;
        cyc = 0;
        while (outs[idx] !== val) begin
            step(1);
            cyc++;
            if (cyc > ms * MSC + 4) timeout();
        end
        check(32'(cyc >= (ms - 1) * MSC), 32'h00000001);
    endtask

    task automatic pwm_measure;
        int start;
        int cyc;
        start = rises;
        cyc = 0;
        while (rises < start + 2) begin
            step(1);
            cyc++;
            if (cyc > 40000) timeout();
        end
        check(32'(per), 32'(exp_period(int'(freq))));
        check(32'(hi), 32'(exp_high(int'(freq), int'(duty))));
    endtask

    task automatic route_sweep(input logic bo);
        logic srcv;
        check(32'(brake_out), 32'(bo));
        for (int i = 0; i < 16; i++) begin
            dout_word[5] = i[1];
            route_sel = {3'h0, i[3], 3'h0, i[2], i[0], 2'h0, 5'h05};
            step(3);
            srcv = i[3] ? (bo ^ i[2]) : ~i[2];
            check(32'(routed_out), 32'(srcv & (i[1] ^ i[0])));
        end
    endtask

    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial begin
        step(16);
        rst = 1'b0;
        step(1);
        check(32'({outs, brake_out, routed_out}), 32'h00000000);
        $display("test reset done");
        dout_word[0] = 1'b1;
        step(5);
        check(32'(energised), 32'h00000000);
        dout_word[0] = 1'b0;
        $display("test auto closed done");
        duty = 7'(2 + $unsigned($random(seed)) % 98);
        op_en = 1'b1;
        step(1);
        check(32'({energised, cur_on}), 32'h00000001);
        timed_wait(2, 1'b1, int'(d_on));
        check(32'(travel), 32'h00000000);
        timed_wait(3, 1'b1, int'(d_rel));
        $display("test enable sequence done");
        pwm_measure();
        freq = 16'h7530;
        duty = 7'h01;
        pwm_measure();
        duty = 7'h64;
        lowc = 0;
        repeat (12600) begin
            step(1);
            lowc += (brake_out === 1'b1) ? 0 : 1;
        end
        check(32'(lowc), 32'h00000000);
        $display("test pwm done");
        route_sweep(1'b1);
        op_en = 1'b0;
        step(1);
        check(32'({energised, travel, halt}), 32'h00000005);
        step(20);
        check(32'(energised), 32'h00000001);
        standstill = 1'b1;
        timed_wait(2, 1'b0, int'(d_stop));
        check(32'(cur_on), 32'h00000001);
        timed_wait(0, 1'b0, int'(d_eng));
        step(3);
        check(32'(brake_out), 32'h00000000);
        $display("test disable sequence done");
        op_en = 1'b1;
        step(5);
        op_en = 1'b0;
        step(1);
        check(32'({energised, cur_on}), 32'h00000001);
        timed_wait(0, 1'b0, int'(d_eng));
        $display("test early drop done");
        route_sweep(1'b0);
        submode = 16'h0000;
        dout_word[0] = 1'b1;
        step(2);
        check(32'({travel, energised}), 32'h00000001);
        dout_word[0] = 1'b0;
        step(2);
        check(32'(energised), 32'h00000000);
        $display("test manual done");
        print_verdict();
    end
endmodule
`default_nettype wire
